// ==== design/rsc_pkg.sv ====
`default_nettype none
package rsc_pkg;
  // frame layout
  localparam int RSC_FRAME_BITS = 24;
  localparam int RSC_CMD_MSB = 23;
  localparam int RSC_CMD_LSB = 20;
  localparam int RSC_REF_OFF_POS = 0;
  // command codes
  localparam logic [3:0] RSC_CMD_REF_SETUP = 4'h7;
  // reset values
  localparam logic RSC_REF_CTRL_RST = 1'h0;
  localparam logic [4:0] RSC_CNT_RST = 5'h00;
  localparam logic [23:0] RSC_SHIFT_RST = 24'h000000;
  // pin order and idle levels
  localparam int RSC_PIN_COUNT = 3;
  localparam int RSC_PIN_SCLK = 0;
  localparam int RSC_PIN_SDIN = 1;
  localparam int RSC_PIN_SYNC = 2;
  localparam logic [2:0] RSC_PIN_RST = 3'h5;
  typedef enum logic [1:0] {
    RSC_IDLE = 2'b00,
    RSC_SHIFT = 2'b01,
    RSC_FULL = 2'b10
  } rsc_state_t;
endpackage : rsc_pkg
`default_nettype wire

// ==== design/rsc_sync.sv ====
`default_nettype none
module rsc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule : rsc_sync
`default_nettype wire

// ==== design/rsc_top.sv ====
// Overview of operation
// - reference on after power-up reset
// - command 0111 touches only reference bit
// - bit zero one turns reference off
// - 24-bit word acted on at sync rise
`default_nettype none
module rsc_top
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sync_n,
  output logic ref_off,
  output logic ref_enable
);
  // ==========================================================
  // pin synchronisers
  logic [RSC_PIN_COUNT-1:0] pin_raw;
  logic [RSC_PIN_COUNT-1:0] pin_sync;
  logic sclk_s;
  logic sdin_s;
  logic sync_n_s;

  assign pin_raw[RSC_PIN_SCLK] = sclk;
  assign pin_raw[RSC_PIN_SDIN] = sdin;
  assign pin_raw[RSC_PIN_SYNC] = sync_n;

  // each pin resets to its idle level
  for (genvar g = 0; g < RSC_PIN_COUNT; g++) begin : gen_pin_sync
    rsc_sync #(
      .RST_VAL(RSC_PIN_RST[g])
    ) rsc_sync_inst (
      .clk(clk),
      .resetn(resetn),
      .async_in(pin_raw[g]),
      .sync_out(pin_sync[g])
    );
  end

  assign sclk_s = pin_sync[RSC_PIN_SCLK];
  assign sdin_s = pin_sync[RSC_PIN_SDIN];
  assign sync_n_s = pin_sync[RSC_PIN_SYNC];

  // ==========================================================
  // serial clock edges
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic sclk_fall;

  always_comb begin
    sclk_prev_d = sclk_s;
    sclk_fall = sclk_prev_q & ~sclk_s;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_q <= RSC_PIN_RST[RSC_PIN_SCLK];
    end else begin
      sclk_prev_q <= sclk_prev_d;
    end
  end

  // ==========================================================
  // frame sync edges
  logic sync_prev_q;
  logic sync_prev_d;
  logic sync_fall;
  logic sync_rise;

  always_comb begin
    sync_prev_d = sync_n_s;
    sync_fall = sync_prev_q & ~sync_n_s;
    sync_rise = ~sync_prev_q & sync_n_s;
  end

  // idle level at reset avoids a false edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_prev_q <= RSC_PIN_RST[RSC_PIN_SYNC];
    end else begin
      sync_prev_q <= sync_prev_d;
    end
  end

  // ==========================================================
  // frame sequencing
  rsc_state_t state_q;
  rsc_state_t state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic take_bit;
  logic frame_done;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    take_bit = 1'b0;
    frame_done = 1'b0;
    case (state_q)
      RSC_IDLE: begin
        if (sync_fall) begin
          state_d = RSC_SHIFT;
          cnt_d = RSC_CNT_RST;
        end
      end

      RSC_SHIFT: begin
        if (sync_rise) begin
          // a short frame is dropped
          state_d = RSC_IDLE;
        end else if (sclk_fall) begin
          take_bit = 1'b1;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(RSC_FRAME_BITS - 1)) begin
            state_d = RSC_FULL;
          end
        end
      end

      RSC_FULL: begin
        // extra falls are ignored
        if (sync_rise) begin
          state_d = RSC_IDLE;
          frame_done = 1'b1;
        end
      end

      default: begin
        state_d = RSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= RSC_IDLE;
      cnt_q <= RSC_CNT_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // frame shift register
  logic [23:0] shift_q;
  logic [23:0] shift_d;

  always_comb begin
    shift_d = shift_q;
    if (take_bit) begin
      // msb arrives first
      shift_d = {shift_q[22:0], sdin_s};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= RSC_SHIFT_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ==========================================================
  // command decode
  logic [3:0] command_field;
  logic ref_off_bit;
  logic setup_hit;

  assign command_field = shift_q[RSC_CMD_MSB:RSC_CMD_LSB];
  assign ref_off_bit = shift_q[RSC_REF_OFF_POS];

  always_comb begin
    setup_hit = 1'b0;
    case (command_field)
      RSC_CMD_REF_SETUP: begin
        setup_hit = frame_done;
      end
      default: begin
        // other commands leave the bit alone
        setup_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // reference control
  logic ref_off_bit_q;
  logic ref_off_bit_d;

  always_comb begin
    ref_off_bit_d = ref_off_bit_q;
    if (setup_hit) begin
      ref_off_bit_d = ref_off_bit;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_off_bit_q <= RSC_REF_CTRL_RST;
    end else begin
      ref_off_bit_q <= ref_off_bit_d;
    end
  end

  // ==========================================================
  // outputs
  assign ref_off = ref_off_bit_q;
  assign ref_enable = ~ref_off_bit_q;
endmodule : rsc_top
`default_nettype wire

// ==== test/rsc_properties.sv ====
`default_nettype none
module rsc_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sync_n,
  input wire logic ref_off,
  input wire logic ref_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ENABLE_INV: assert property (ref_enable != ref_off)
    else $error("enable not inverse");
  AST_RESET_ON: assert property ($rose(resetn) |-> !ref_off)
    else $error("reference off after reset");
  AST_HOLD: assert property ($changed(ref_off) |-> $past(sync_n, 3))
    else $error("change without frame end");
  AST_FRAME_QUIET: assert property (!sync_n [*6] |-> $stable(ref_off))
    else $error("change inside frame");
  AST_IDLE_QUIET: assert property (sync_n [*8] |-> $stable(ref_off))
    else $error("change while idle");
  AST_NO_EARLY: assert property ($rose(sync_n) |-> $stable(ref_off) [*3])
    else $error("change too soon after frame end");
  cover property ($rose(ref_off));
  cover property ($fell(ref_off));
  cover property ($rose(sync_n));
endmodule : rsc_properties
bind rsc_top rsc_properties rsc_properties_inst (.clk(clk), .resetn(resetn),
  .sync_n(sync_n), .ref_off(ref_off), .ref_enable(ref_enable));
`default_nettype wire

// ==== test/rsc_host.sv ====
`default_nettype none
module rsc_host (
  input wire logic clk,
  output logic sclk,
  output logic sdin,
  output logic sync_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b1;
    sdin = 1'b0;
    sync_n = 1'b1;
  end
  task automatic send(input logic [23:0] w, input int n);
    sync_n <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      sdin <= w[i];
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
    end
    repeat (5) @(posedge clk);
    sync_n <= 1'b1;
    sdin <= ~sdin;
    repeat (8) @(posedge clk);
  endtask : send
endmodule : rsc_host
`default_nettype wire

// ==== test/rsc_top_tb_top.sv ====
`default_nettype none
module rsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, sclk, sdin, sync_n, ref_off, ref_enable;
  int failures = 0;
  int cmp_count = 0;
  rsc_top rsc_top_inst (.clk(clk), .resetn(resetn), .sclk(sclk), .sdin(sdin),
    .sync_n(sync_n), .ref_off(ref_off), .ref_enable(ref_enable));
  rsc_host rsc_host_inst (.clk(clk), .sclk(sclk), .sdin(sdin), .sync_n(sync_n));
  task automatic check(input string name, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s exp %b seen %b", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic frame(input logic [23:0] w, input int n, input logic exp);
    rsc_host_inst.send(w, n);
    check("ref_off", ref_off, exp);
    check("ref_enable", ref_enable, !exp);
  endtask : frame
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #60000;
    failures++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("ref_off", ref_off, 1'b0);
    check("ref_enable", ref_enable, 1'b1);
    frame(24'h7ffffe, 24, 1'b0);
    frame(24'h700001, 24, 1'b1);
    frame(24'h4ffffe, 24, 1'b1);
    frame(24'hf00000, 24, 1'b1);
    frame(24'he00000, 23, 1'b1);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("ref_off", ref_off, 1'b0);
    check("ref_enable", ref_enable, 1'b1);
    frame(24'h700001, 24, 1'b1);
    frame(24'h7ffffe, 24, 1'b0);
    close_out();
  end
endmodule : rsc_top_tb_top
`default_nettype wire
